/* File: core/l1_user_ctrl.sv */
// Purpose: User side layer 1 state controller of a primary rate interface.
// Assumes: Frame alignment and CRC checking are done upstream and reported per frame.
// Notes: The link is sampled through two flip-flops since it comes from another unit.
`timescale 1ns/1ps
`default_nettype none
module l1_user_ctrl
  import l1_pri_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Link toward the network side.
  l1_pri_link_if.user link,
  // Local conditions.
  input wire logic power_ok,
  input wire logic frame_aligned,
  input wire logic crc_err_stb,
  input wire logic net_option,
  input wire logic report_in_f5,
  // Status toward layer 2 and management.
  output l1_pri_pkg::user_state_type state,
  output logic act_ind,
  output logic deact_ind,
  output logic err_ind,
  output logic [2:0] err_code
);
  import l1_pri_pkg::*;

  // Synchroniser stages for the link inputs.
  logic [5:0] sync1_reg, sync2_reg;
  logic [1:0] kind1_reg, kind2_reg;
  logic stb_d_reg;
  user_state_type state_reg, state_next;
  logic [9:0] win_cnt_reg, win_cnt_next;
  logic [1:0] zero_cnt_reg, zero_cnt_next;
  logic ais_reg, ais_next;
  logic rai_reg, rai_next;
  logic [$clog2(RAI_CCE_CYCLES+1)-1:0] cce_cnt_reg, cce_cnt_next;
  logic cce_reg, cce_next;
  logic pend_err_reg, pend_err_next;
  logic [1:0] up_kind_reg, up_kind_next;
  logic up_stb_reg, up_stb_next, up_a_reg, up_a_next, up_e_reg, up_e_next;
  logic act_reg, act_next, deact_reg, deact_next, err_reg, err_next;
  logic [2:0] code_reg, code_next;

  // Two-flop capture; only stage two feeds any logic.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      kind1_reg <= 2'h0;
      kind2_reg <= 2'h0;
      stb_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {link.dn_bit_stb, link.dn_bit, link.dn_frame_stb, link.dn_a_bit,
                    link.dn_e_bit, link.dn_timing};
      sync2_reg <= sync1_reg;
      kind1_reg <= link.dn_kind;
      kind2_reg <= kind1_reg;
      stb_d_reg <= sync2_reg[5];
    end
  end

  logic bit_stb, rx_bit, frame_stb, rx_a, rx_e, signal_lost;
  assign bit_stb = sync2_reg[5] & ~stb_d_reg;
  assign rx_bit = sync2_reg[4];
  assign frame_stb = sync2_reg[3];
  assign rx_a = sync2_reg[2];
  assign rx_e = sync2_reg[1];
  // No frames and no AIS on the line is loss of signal; so is missing timing, with or without frames.
  assign signal_lost = (kind2_reg == 2'(TX_NONE)) | ~sync2_reg[0];

  // Detectors for AIS, RAI and RAI with continuous CRC errors.
  always_comb begin
    win_cnt_next = win_cnt_reg;
    zero_cnt_next = zero_cnt_reg;
    ais_next = ais_reg;
    rai_next = rai_reg;
    cce_cnt_next = cce_cnt_reg;
    cce_next = cce_reg;
    if (frame_aligned) begin
      ais_next = 1'b0;
      win_cnt_next = 10'h000;
      zero_cnt_next = 2'h0;
    end else if (bit_stb) begin
      if (!rx_bit && zero_cnt_reg != 2'(AIS_ZERO_LIMIT)) begin
        zero_cnt_next = zero_cnt_reg + 2'h1;
      end
      if (win_cnt_reg == 10'(AIS_WINDOW_BITS - 1)) begin
        // Window closes: fewer than three zeros means AIS.
        ais_next = (zero_cnt_next < 2'(AIS_ZERO_LIMIT));
        win_cnt_next = 10'h000;
        zero_cnt_next = 2'h0;
      end else begin
        win_cnt_next = win_cnt_reg + 10'h001;
      end
    end
    if (!frame_aligned) begin
      rai_next = 1'b0;
    end else if (frame_stb) begin
      rai_next = rx_a;
    end
    // The counter runs only while A one and E zero persist.
    if (!frame_aligned || net_option != NET_OPTION_2) begin
      cce_cnt_next = '0;
      cce_next = 1'b0;
    end else if (frame_stb) begin
      if (rx_a && !rx_e) begin
        if (cce_cnt_reg != ($bits(cce_cnt_reg))'(RAI_CCE_CYCLES)) begin
          cce_cnt_next = cce_cnt_reg + 1'b1;
        end
      end else begin
        cce_cnt_next = '0;
        cce_next = 1'b0;
      end
    end else if (cce_cnt_reg != ($bits(cce_cnt_reg))'(RAI_CCE_CYCLES) && cce_cnt_reg != '0) begin
      cce_cnt_next = cce_cnt_reg + 1'b1;
    end
    if (cce_cnt_next == ($bits(cce_cnt_reg))'(RAI_CCE_CYCLES)) begin
      cce_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      win_cnt_reg <= 10'h000;
      zero_cnt_reg <= 2'h0;
      ais_reg <= 1'b0;
      rai_reg <= 1'b0;
      cce_cnt_reg <= '0;
      cce_reg <= 1'b0;
    end else begin
      win_cnt_reg <= win_cnt_next;
      zero_cnt_reg <= zero_cnt_next;
      ais_reg <= ais_next;
      rai_reg <= rai_next;
      cce_cnt_reg <= cce_cnt_next;
      cce_reg <= cce_next;
    end
  end

  // State choice, indications and the transmitted frame contents.
  always_comb begin
    state_next = state_reg;
    pend_err_next = pend_err_reg | crc_err_stb;
    up_kind_next = up_kind_reg;
    up_stb_next = 1'b0;
    up_a_next = up_a_reg;
    up_e_next = up_e_reg;
    act_next = 1'b0;
    deact_next = 1'b0;
    err_next = 1'b0;
    code_next = code_reg;
    if (!power_ok) begin
      state_next = F0_OFF;
    end else if (state_reg == F0_OFF) begin
      state_next = F6_PWRON;
    end else if (state_reg != F6_PWRON || !signal_lost || ais_reg) begin
      // F6 is left only once the line has been evaluated.
      if (signal_lost && !ais_reg) state_next = F3_FC2;
      else if (ais_reg) state_next = F4_FC3;
      else if (!frame_aligned) state_next = F3_FC2;
      else if (cce_reg) state_next = F5_FC4;
      else if (rai_reg) state_next = F2_FC1;
      else state_next = F1_OPER;
    end
    if (state_next != state_reg) begin
      if (state_next == F1_OPER) begin
        act_next = 1'b1;
      end else if (state_next != F6_PWRON) begin
        err_next = 1'b1;
        code_next = (state_next == F0_OFF) ? 3'h0 : 3'(state_next) - 3'h1;
        deact_next = (state_reg == F1_OPER);
      end
    end
    unique case (state_next)
      F0_OFF, F6_PWRON: begin
        up_kind_next = 2'(TX_NONE);
        up_a_next = 1'b0;
        up_e_next = 1'b1;
        pend_err_next = 1'b0;
      end
      F3_FC2, F4_FC3: begin
        up_kind_next = 2'(TX_FRAMES);
        up_a_next = 1'b1;
      end
      F1_OPER, F2_FC1, F5_FC4: begin
        up_kind_next = 2'(TX_FRAMES);
        up_a_next = 1'b0;
      end
    endcase
    // One frame goes out per received frame, carrying any pending CRC error.
    if (frame_stb && up_kind_next == 2'(TX_FRAMES)) begin
      up_stb_next = 1'b1;
      // Error reports are suppressed in F5 unless asked for.
      up_e_next = ~(pend_err_reg | crc_err_stb) |
                  (state_next == F5_FC4 && !report_in_f5);
      pend_err_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= F0_OFF;
      pend_err_reg <= 1'b0;
      up_kind_reg <= 2'(TX_NONE);
      up_stb_reg <= 1'b0;
      up_a_reg <= 1'b0;
      up_e_reg <= 1'b1;
      act_reg <= 1'b0;
      deact_reg <= 1'b0;
      err_reg <= 1'b0;
      code_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
      pend_err_reg <= pend_err_next;
      up_kind_reg <= up_kind_next;
      up_stb_reg <= up_stb_next;
      up_a_reg <= up_a_next;
      up_e_reg <= up_e_next;
      act_reg <= act_next;
      deact_reg <= deact_next;
      err_reg <= err_next;
      code_reg <= code_next;
    end
  end

  // Every output comes straight from its register.
  assign state = state_reg;
  assign act_ind = act_reg;
  assign deact_ind = deact_reg;
  assign err_ind = err_reg;
  assign err_code = code_reg;
  assign link.up_kind = tx_kind_type'(up_kind_reg);
  assign link.up_frame_stb = up_stb_reg;
  assign link.up_a_bit = up_a_reg;
  assign link.up_e_bit = up_e_reg;
endmodule // l1_user_ctrl
`default_nettype wire

/* File: pkg/l1_pri_pkg.sv */
// Purpose: Shared constants and types for the primary rate layer 1 state controllers.
// Assumes: One 50 MHz system clock on both ends; line bits arrive as qualified strobes.
// Notes: Holds state enumerations, line-signal codes, option codes and timing counts.
package l1_pri_pkg;
  // User side states.
  typedef enum logic [2:0] {
    F0_OFF, F1_OPER, F2_FC1, F3_FC2, F4_FC3, F5_FC4, F6_PWRON
  } user_state_type;
  // Network side states.
  typedef enum logic [2:0] {
    G0_OFF, G1_OPER, G2_FC1, G3_FC2, G4_FC3, G5_FC4, G6_PWRON
  } net_state_type;
  // What a transmitter puts on the line.
  typedef enum logic [1:0] {
    TX_NONE, TX_FRAMES, TX_AIS
  } tx_kind_type;
  // System clock period in ns.
  localparam int CLK_PERIOD_NS = 20;
  // Persistence check for RAI with continuous CRC errors, in ms.
  localparam int RAI_CCE_MIN_MS = 10;
  localparam int RAI_CCE_MAX_MS = 50;
  // Least check time in cycles, rounded up.
  localparam int RAI_CCE_CYCLES = (RAI_CCE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // AIS window and zero threshold.
  localparam int AIS_WINDOW_BITS = 512;
  localparam int AIS_ZERO_LIMIT = 3;
  // Network option codes.
  localparam logic NET_OPTION_1 = 1'b0;
  localparam logic NET_OPTION_2 = 1'b1;
  // Reset value of the user side error code register.
  localparam logic [2:0] STATE_RESET = 3'h0;
endpackage

/* File: pkg/l1_pri_link_if.sv */
// Purpose: Link between the user side and the network side controllers.
// Assumes: Both ends run on one clock; a bit strobe marks each line bit.
// Notes: Carries the frame-level abstraction of each direction.
`timescale 1ns/1ps
`default_nettype none
interface l1_pri_link_if;
  import l1_pri_pkg::*;
  // Network to user direction.
  tx_kind_type dn_kind;
  logic dn_bit_stb;
  logic dn_bit;
  logic dn_frame_stb;
  logic dn_a_bit;
  logic dn_e_bit;
  logic dn_timing;
  // User to network direction.
  tx_kind_type up_kind;
  logic up_frame_stb;
  logic up_a_bit;
  logic up_e_bit;
  modport user (
    input dn_kind, dn_bit_stb, dn_bit, dn_frame_stb, dn_a_bit, dn_e_bit, dn_timing,
    output up_kind, up_frame_stb, up_a_bit, up_e_bit
  );
  modport net (
    output dn_kind, dn_bit_stb, dn_bit, dn_frame_stb, dn_a_bit, dn_e_bit, dn_timing,
    input up_kind, up_frame_stb, up_a_bit, up_e_bit
  );
endinterface
`default_nettype wire

/* File: core/l1_net_ctrl.sv */
// Purpose: Network side layer 1 state controller of a primary rate interface.
// Assumes: Fault states other than G2 are commanded by the network's own supervision; G2 follows received RAI.
// Notes: Frames and line bits are generated from one free counter of the system clock.
`timescale 1ns/1ps
`default_nettype none
module l1_net_ctrl
  import l1_pri_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Link toward the user side.
  l1_pri_link_if.net link,
  // Local conditions.
  input wire logic power_ok,
  input wire logic line_ok,
  input wire logic timing_ok,
  input wire logic upstream_ok,
  input wire logic crc_err_stb,
  // Status.
  output l1_pri_pkg::net_state_type state,
  output logic rai_seen
);
  import l1_pri_pkg::*;

  net_state_type state_reg, state_next;
  logic [7:0] div_reg, div_next;
  logic [1:0] kind_reg, kind_next;
  logic bstb_reg, bstb_next, bit_reg, bit_next, fstb_reg, fstb_next;
  logic a_reg, a_next, e_reg, e_next, tim_reg, tim_next, pend_reg, pend_next;
  logic [1:0] ua1_reg, ua2_reg;
  logic rai_reg;

  // Upstream A bit and frame strobe pass two flip-flops.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ua1_reg <= 2'h0;
      ua2_reg <= 2'h0;
      rai_reg <= 1'b0;
    end else begin
      ua1_reg <= {link.up_frame_stb, link.up_a_bit};
      ua2_reg <= ua1_reg;
      rai_reg <= ua2_reg[1] ? ua2_reg[0] : rai_reg;
    end
  end

  // State, timing and downstream frame generation.
  always_comb begin
    state_next = state_reg;
    div_next = div_reg + 8'h01;
    pend_next = pend_reg | crc_err_stb;
    bstb_next = (div_reg[1:0] == 2'h0);
    fstb_next = (div_reg == 8'h00);
    if (!power_ok) state_next = G0_OFF;
    else if (state_reg == G0_OFF) state_next = G6_PWRON;
    else if (!line_ok) state_next = G5_FC4;
    else if (!upstream_ok) state_next = G4_FC3;
    else if (!timing_ok) state_next = G3_FC2;
    else if (rai_reg) state_next = G2_FC1;
    else state_next = G1_OPER;
    kind_next = 2'(TX_FRAMES);
    tim_next = 1'b1;
    a_next = 1'b0;
    e_next = 1'b1;
    bit_next = div_reg[2];
    unique case (state_next)
      G0_OFF, G6_PWRON: begin
        kind_next = 2'(TX_NONE);
        tim_next = 1'b0;
      end
      G1_OPER: e_next = ~pend_reg;
      G2_FC1: begin
        a_next = 1'b1;
        e_next = ~pend_reg;
      end
      G3_FC2: tim_next = 1'b0;
      G4_FC3: begin
        kind_next = 2'(TX_AIS);
        tim_next = 1'b0;
        bit_next = 1'b1;
      end
      G5_FC4: begin
        a_next = 1'b1;
        e_next = 1'b0;
      end
    endcase
    if (fstb_next) pend_next = crc_err_stb;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= G0_OFF;
      div_reg <= 8'h00;
      kind_reg <= 2'(TX_NONE);
      bstb_reg <= 1'b0;
      bit_reg <= 1'b0;
      fstb_reg <= 1'b0;
      a_reg <= 1'b0;
      e_reg <= 1'b1;
      tim_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      kind_reg <= kind_next;
      bstb_reg <= bstb_next;
      bit_reg <= bit_next;
      fstb_reg <= fstb_next && kind_next == 2'(TX_FRAMES);
      a_reg <= a_next;
      e_reg <= e_next;
      tim_reg <= tim_next;
      pend_reg <= pend_next;
    end
  end

  assign state = state_reg;
  assign rai_seen = rai_reg;
  assign link.dn_kind = tx_kind_type'(kind_reg);
  assign link.dn_bit_stb = bstb_reg;
  assign link.dn_bit = bit_reg;
  assign link.dn_frame_stb = fstb_reg;
  assign link.dn_a_bit = a_reg;
  assign link.dn_e_bit = e_reg;
  assign link.dn_timing = tim_reg;
endmodule // l1_net_ctrl
`default_nettype wire

/* File: test/l1_pri_link_monitor.sv */
// Purpose: Concurrent checks on the link that joins the user and network controllers.
// Assumes: One clock and one asynchronous active-low reset for both ends.
// Notes: Sees only link signals, so the user state is judged from what it sends.
`timescale 1ns/1ps
`default_nettype none
module l1_pri_link_monitor
  import l1_pri_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Network to user direction.
  input wire tx_kind_type dn_kind,
  input wire logic dn_bit_stb,
  input wire logic dn_bit,
  input wire logic dn_frame_stb,
  input wire logic dn_timing,
  // User to network direction.
  input wire tx_kind_type up_kind,
  input wire logic up_frame_stb,
  input wire logic up_a_bit
);
  // Long enough for the user side to settle on lost timing, yet short enough that
  // the frames still flowing in G3 are seen after it.
  localparam int LOSS_HOLD = 1024;
  int loss_cnt_reg;
  int loss_cnt_next;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Counts cycles without timed frames; it saturates so that it never wraps.
  always_comb begin
    loss_cnt_next = loss_cnt_reg;
    if (dn_kind == TX_FRAMES && dn_timing) begin
      loss_cnt_next = 0;
    end else if (loss_cnt_reg < LOSS_HOLD) begin
      loss_cnt_next = loss_cnt_reg + 1;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      loss_cnt_reg <= 0;
    end else begin
      loss_cnt_reg <= loss_cnt_next;
    end
  end
  // An upward frame is a single-cycle pulse.
  sequence s_up_pulse;
    up_frame_stb ##1 !up_frame_stb;
  endsequence
  // A downward frame arrived a few cycles before, through the input flops.
  sequence s_down_recent;
    $past(dn_frame_stb, 2) || $past(dn_frame_stb, 3) || $past(dn_frame_stb, 4) ||
      $past(dn_frame_stb, 5);
  endsequence
  a_up_frame_silent: assert property (up_frame_stb |-> up_kind == TX_FRAMES)
    else $error("Upward frame while the user side is silent.");
  a_up_frame_pulse: assert property (up_frame_stb |-> s_up_pulse)
    else $error("Upward frame strobe longer than one cycle.");
  a_up_frame_paired: assert property (up_frame_stb |-> s_down_recent)
    else $error("Upward frame without a downward frame before it.");
  a_dn_frame_pulse: assert property (dn_frame_stb |=> !dn_frame_stb)
    else $error("Downward frame strobe longer than one cycle.");
  a_ais_all_ones: assert property (dn_kind == TX_AIS && dn_bit_stb |-> dn_bit)
    else $error("Zero bit sent during AIS.");
  a_ais_no_frames: assert property (dn_kind == TX_AIS |-> !dn_frame_stb && !dn_timing)
    else $error("Frames or timing sent during AIS.");
  a_off_no_signal: assert property (dn_kind == TX_NONE |-> !dn_frame_stb && !dn_timing)
    else $error("Frames or timing sent while the network side is off.");
  a_loss_sends_rai: assert property (
    loss_cnt_reg == LOSS_HOLD && up_frame_stb |-> up_a_bit)
    else $error("No RAI sent after lasting loss of network frames.");
endmodule // l1_pri_link_monitor
`default_nettype wire

/* File: test/test_isdn_pri_layer1_user_state_ctrl.sv */
// Purpose: Self-checking bench joining the user and network controllers.
// Assumes: Inputs change on the falling edge; outputs are read 1 ns after the rising edge.
// Notes: The 10 ms persistence count is too long to run, so only its early side is seen.
`timescale 1ns/1ps
`default_nettype none
module test_isdn_pri_layer1_user_state_ctrl;
  import l1_pri_pkg::*;
  typedef struct packed {
    logic npwr; logic line; logic tmg; logic upst; logic algn; logic opt;
    user_state_type ust; net_state_type nst; logic ua;
  } row_type;
  // Network inputs, user inputs, then expected user state, network state and A bit.
  localparam row_type ROWS [8] = '{
    '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, F1_OPER, G1_OPER, 1'h0},
    '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, F3_FC2, G3_FC2, 1'h1},
    '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, F4_FC3, G4_FC3, 1'h1},
    '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, F2_FC1, G5_FC4, 1'h0},
    '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, F2_FC1, G5_FC4, 1'h0},
    '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, F3_FC2, G2_FC1, 1'h1},
    '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, F3_FC2, G0_OFF, 1'h1},
    '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, F1_OPER, G1_OPER, 1'h0}};
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic u_power_ok = 1'h1, frame_aligned = 1'h1, u_crc_err_stb = 1'h0, net_option = 1'h0;
  logic report_in_f5 = 1'h0;
  logic n_power_ok = 1'h1, line_ok = 1'h1, timing_ok = 1'h1, upstream_ok = 1'h1;
  logic n_crc_err_stb = 1'h0;
  user_state_type u_state;
  net_state_type n_state;
  logic act_ind, deact_ind, err_ind, rai_seen;
  logic [2:0] err_code;
  int mismatches = 0;
  int checks = 0;
  l1_pri_link_if l1_pri_link_if_i ();
  wire logic up_frame = l1_pri_link_if_i.up_frame_stb;
  wire logic up_e = l1_pri_link_if_i.up_e_bit;
  l1_user_ctrl l1_user_ctrl_i (.sys_clk(sys_clk), .resetn(resetn), .link(l1_pri_link_if_i),
    .power_ok(u_power_ok), .frame_aligned(frame_aligned), .crc_err_stb(u_crc_err_stb),
    .net_option(net_option), .report_in_f5(report_in_f5), .state(u_state), .act_ind(act_ind),
    .deact_ind(deact_ind), .err_ind(err_ind), .err_code(err_code));
  l1_net_ctrl l1_net_ctrl_i (.sys_clk(sys_clk), .resetn(resetn), .link(l1_pri_link_if_i),
    .power_ok(n_power_ok), .line_ok(line_ok), .timing_ok(timing_ok), .upstream_ok(upstream_ok),
    .crc_err_stb(n_crc_err_stb), .state(n_state), .rai_seen(rai_seen));
  l1_pri_link_monitor l1_pri_link_monitor_i (.sys_clk(sys_clk), .resetn(resetn),
    .dn_kind(l1_pri_link_if_i.dn_kind), .dn_bit_stb(l1_pri_link_if_i.dn_bit_stb),
    .dn_bit(l1_pri_link_if_i.dn_bit), .dn_frame_stb(l1_pri_link_if_i.dn_frame_stb),
    .dn_timing(l1_pri_link_if_i.dn_timing), .up_kind(l1_pri_link_if_i.up_kind),
    .up_frame_stb(up_frame), .up_a_bit(l1_pri_link_if_i.up_a_bit));
  // Free-running system clock.
  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp_user(input user_state_type got, input user_state_type exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t user state %s, expected %s", $time, got.name(), exp.name());
    end
  endtask
  task automatic cmp_net(input net_state_type got, input net_state_type exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t network state %s, expected %s", $time, got.name(), exp.name());
    end
  endtask
  task automatic cmp_val(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t value %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int which);
    case (which)
      0: return up_frame;
      1: return l1_pri_link_if_i.dn_frame_stb;
      2: return deact_ind;
      default: return act_ind;
    endcase
  endfunction
  // Polls 1 ns after each rising edge; a pulse stands for one cycle only.
  task automatic wait_for(input int which, input int bound);
    for (int n = 0; n < bound; n++) begin
      @(posedge sys_clk);
      #1;
      if (pick(which) === 1'h1) return;
    end
    $display("[ERR] %0t wait ran out", $time);
    mismatches++;
    print_verdict();
  endtask
  task automatic check_reset();
    cmp_user(u_state, F0_OFF);
    cmp_net(n_state, G0_OFF);
    cmp_val({1'h0, l1_pri_link_if_i.up_kind}, {1'h0, TX_NONE});
    cmp_val({2'h0, up_e}, 3'h1);
    cmp_val(err_code, 3'h0);
  endtask
  // Power return lands in F6 on the first edge after reset release.
  task automatic release_reset();
    @(negedge sys_clk);
    resetn = 1'h1;
    @(posedge sys_clk);
    #1;
    cmp_user(u_state, F6_PWRON);
    $display("Test reset done");
  endtask
  initial begin
    // Reset stands over the first 16 rising edges.
    repeat (16) @(posedge sys_clk);
    #1;
    check_reset();
    release_reset();
    // Each row waits out an AIS window of 512 bits of 4 clocks, twice, plus frames.
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      n_power_ok = ROWS[i].npwr;
      line_ok = ROWS[i].line;
      timing_ok = ROWS[i].tmg;
      upstream_ok = ROWS[i].upst;
      frame_aligned = ROWS[i].algn;
      net_option = ROWS[i].opt;
      repeat (6000) @(posedge sys_clk);
      #1;
      cmp_user(u_state, ROWS[i].ust);
      cmp_net(n_state, ROWS[i].nst);
      cmp_val({2'h0, l1_pri_link_if_i.up_a_bit}, {2'h0, ROWS[i].ua});
      cmp_val({2'h0, rai_seen}, {2'h0, ROWS[i].ua});
      $display("Test row %0d done", i);
    end
    // Errors are raised just after an up frame so the next frames must carry them.
    wait_for(0, 300);
    @(negedge sys_clk);
    u_crc_err_stb = 1'h1;
    n_crc_err_stb = 1'h1;
    @(negedge sys_clk);
    u_crc_err_stb = 1'h0;
    n_crc_err_stb = 1'h0;
    wait_for(1, 300);
    cmp_val({2'h0, l1_pri_link_if_i.dn_e_bit}, 3'h0);
    wait_for(0, 300);
    cmp_val({2'h0, up_e}, 3'h0);
    wait_for(0, 300);
    cmp_val({2'h0, up_e}, 3'h1);
    $display("Test crc report done");
    @(negedge sys_clk);
    u_power_ok = 1'h0;
    wait_for(2, 8);
    cmp_user(u_state, F0_OFF);
    cmp_val({2'h0, err_ind}, 3'h1);
    cmp_val(err_code, 3'h0);
    repeat (4) @(posedge sys_clk);
    #1;
    cmp_val({1'h0, l1_pri_link_if_i.up_kind}, {1'h0, TX_NONE});
    @(negedge sys_clk);
    u_power_ok = 1'h1;
    @(posedge sys_clk);
    #1;
    cmp_user(u_state, F6_PWRON);
    wait_for(3, 8000);
    cmp_user(u_state, F1_OPER);
    $display("Test power cycle done");
    @(negedge sys_clk);
    resetn = 1'h0;
    #1;
    check_reset();
    release_reset();
    print_verdict();
  end
endmodule // test_isdn_pri_layer1_user_state_ctrl
`default_nettype wire
